// file: src/udc_ctrl_regs.sv
// Gain, power and burst pin fault control registers with the pulse fault monitor
`timescale 1ns/100ps
`default_nettype none
module udc_ctrl_regs
  import udc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic burst_active,
  input wire logic burst_control_pin_a,
  input wire logic burst_control_pin_b,
  input wire logic fault_clear,
  output logic driver_pulse_fault_flag,
  output logic [1:0] front_amplifier_gain_select,
  output logic [5:0] front_amplifier_gain_half_vv,
  output logic vout_full_scale_5v,
  output logic first_log_stage_off,
  output logic last_log_stage_off,
  output logic [1:0] pin_scheme,
  output logic [2:0] pulse_fault_deglitch_time
);

  logic [7:0] gain_pwr_r;
  logic [7:0] gain_pwr_nxt;
  logic [7:0] pin_time_r;
  logic [7:0] pin_time_nxt;
  logic [5:0] gain_half_r;
  logic [5:0] gain_half_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;

  // Register file
  always_comb begin
    gain_pwr_nxt = gain_pwr_r;
    pin_time_nxt = pin_time_r;
    if (reg_wr_en && (reg_addr == UDC_OFF_GAIN_PWR)) begin
      gain_pwr_nxt = reg_wdata & UDC_MASK_GAIN_PWR;  // see R8, see R9, see R7
    end else if (reg_wr_en && (reg_addr == UDC_OFF_PIN_TIME)) begin
      pin_time_nxt = reg_wdata & UDC_MASK_PIN_TIME;  // see R5, see R1
    end
    gain_half_nxt = udc_gain_half(gain_pwr_nxt[UDC_LSB_GAIN +: 2]);  // see R6
  end

  // Read port answers one cycle after the strobe; unmapped offsets read zero
  always_comb begin
    rd_valid_nxt = reg_rd_en;
    rdata_nxt = rdata_r;
    if (reg_rd_en) begin
      if (reg_addr == UDC_OFF_GAIN_PWR) begin
        rdata_nxt = gain_pwr_r;
      end else if (reg_addr == UDC_OFF_PIN_TIME) begin
        rdata_nxt = pin_time_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_pwr_r <= UDC_RST_GAIN_PWR;
      pin_time_r <= UDC_RST_PIN_TIME;
      gain_half_r <= UDC_GAIN_HALF_C0;
      rdata_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      gain_pwr_r <= gain_pwr_nxt;
      pin_time_r <= pin_time_nxt;
      gain_half_r <= gain_half_nxt;
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // Pulse fault monitor
  logic [2:0] dt_code;
  udc_scheme_e scheme;
  logic check_on;
  logic [UDC_LIM_W-1:0] limit_cyc;
  logic [1:0] watch_en;
  logic [1:0] watch_pin;
  logic [1:0] watch_exp;
  logic both_high_pause;
  logic fault_r;
  logic fault_nxt;

  always_comb begin
    dt_code = pin_time_r[UDC_LSB_DEGLITCH +: 3];
    scheme = udc_scheme_e'(pin_time_r[UDC_LSB_SCHEME +: 2]);
    limit_cyc = udc_timeout_cyc(dt_code);  // see R1
    check_on = burst_active && (dt_code != UDC_DT_CHECK_OFF);  // see R2
    // Scheme 3 has no documented check, so nothing is watched there
    both_high_pause = (scheme == UDC_SCHEME_2) && burst_control_pin_a && burst_control_pin_b;  // see R4
    watch_pin = {burst_control_pin_b, burst_control_pin_a};
    watch_en[0] = check_on && (scheme == UDC_SCHEME_2);  // see R4
    watch_en[1] = check_on && (scheme != UDC_SCHEME_3);  // see R3, see R4
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_watch
      udc_toggle_watch #(
        .CNT_W(UDC_LIM_W)
      ) u_watch (
        .clk(clk),
        .resetn(resetn),
        .enable(watch_en[gi]),
        .pin(watch_pin[gi]),
        .pause(both_high_pause),
        .limit(limit_cyc),
        .expired(watch_exp[gi])
      );
    end
  endgenerate

  // A fault that arrives together with a clear is kept
  always_comb begin
    fault_nxt = fault_r;
    if (fault_clear) begin
      fault_nxt = 1'b0;
    end
    if (|watch_exp) begin
      fault_nxt = 1'b1;  // see R3, see R4
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rd_valid = rd_valid_r;
  assign driver_pulse_fault_flag = fault_r;
  assign front_amplifier_gain_select = gain_pwr_r[UDC_LSB_GAIN +: 2];
  assign front_amplifier_gain_half_vv = gain_half_r;
  assign vout_full_scale_5v = gain_pwr_r[UDC_BIT_VOUT_SCALE];
  assign first_log_stage_off = gain_pwr_r[UDC_BIT_FIRST_OFF];
  assign last_log_stage_off = gain_pwr_r[UDC_BIT_LAST_OFF];
  assign pin_scheme = pin_time_r[UDC_LSB_SCHEME +: 2];
  assign pulse_fault_deglitch_time = dt_code;

  // Helper counters of quiet cycles, mirrored for the checks below
  logic [UDC_LIM_W-1:0] quiet_h [2];
  logic [1:0] pin_prev_h;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quiet_h[0] <= '0;
      quiet_h[1] <= '0;
      pin_prev_h <= 2'b00;
    end else begin
      pin_prev_h <= watch_pin;
      for (int i = 0; i < 2; i++) begin
        if (!watch_en[i] || both_high_pause || (watch_pin[i] ^ pin_prev_h[i])) begin
          quiet_h[i] <= '0;
        end else if (quiet_h[i] != '1) begin
          quiet_h[i] <= quiet_h[i] + 1'b1;
        end
      end
    end
  end

  property p_r1_timeout;
    @(posedge clk) disable iff (!resetn)
    ($rose(fault_r) && ($past(dt_code, 2) == 3'h6) && ($past(scheme, 2) == UDC_SCHEME_0))
      |-> ($past(quiet_h[1]) >= 12'd81);
  endproperty
  a_r1_timeout: assert property (p_r1_timeout) else $error("fault before 4 us deglitch time"); // see R1

  property p_r2_disabled;
    @(posedge clk) disable iff (!resetn)
    $rose(fault_r) |-> ($past(dt_code, 2) != UDC_DT_CHECK_OFF);
  endproperty
  a_r2_disabled: assert property (p_r2_disabled) else $error("fault set with check disabled"); // see R2

  property p_r3_pin_b;
    @(posedge clk) disable iff (!resetn)
    (watch_en[1] && (scheme != UDC_SCHEME_2) && (quiet_h[1] > limit_cyc) && $stable(dt_code))
      |=> fault_r;
  endproperty
  a_r3_pin_b: assert property (p_r3_pin_b) else $error("quiet pin b did not set fault"); // see R3

  property p_r4_pin_a;
    @(posedge clk) disable iff (!resetn)
    (watch_en[0] && (quiet_h[0] > limit_cyc) && $stable(dt_code)) |=> fault_r;
  endproperty
  a_r4_pin_a: assert property (p_r4_pin_a) else $error("quiet pin a did not set fault"); // see R4

  property p_r4_pause;
    @(posedge clk) disable iff (!resetn)
    (!fault_r && both_high_pause && !fault_clear) [*3] |=> !fault_r;
  endproperty
  a_r4_pause: assert property (p_r4_pause) else $error("fault while both pins high"); // see R4

  property p_r5_scheme;
    @(posedge clk) disable iff (!resetn)
    (reg_wr_en && (reg_addr == UDC_OFF_PIN_TIME)) |=> (pin_scheme == $past(reg_wdata[1:0]));
  endproperty
  a_r5_scheme: assert property (p_r5_scheme) else $error("pin scheme not written"); // see R5

  property p_r6_gain;
    @(posedge clk) disable iff (!resetn)
    (reg_wr_en && (reg_addr == UDC_OFF_GAIN_PWR) && (reg_wdata[1:0] == 2'h3))
      |=> (front_amplifier_gain_half_vv == 6'h19) ##1 (front_amplifier_gain_select == 2'h3);
  endproperty
  a_r6_gain: assert property (p_r6_gain) else $error("gain code 3 not 12.5 V/V"); // see R6

  property p_r7_scale;
    @(posedge clk) disable iff (!resetn)
    (reg_wr_en && (reg_addr == UDC_OFF_GAIN_PWR)) |=> (vout_full_scale_5v == $past(reg_wdata[2]));
  endproperty
  a_r7_scale: assert property (p_r7_scale) else $error("output scaling bit not written"); // see R7

  property p_r8_first;
    @(posedge clk) disable iff (!resetn)
    (reg_rd_en && (reg_addr == UDC_OFF_GAIN_PWR)) |=> (reg_rd_valid && (reg_rdata[7] == $past(first_log_stage_off)));
  endproperty
  a_r8_first: assert property (p_r8_first) else $error("first stage off bit mismatch"); // see R8

  property p_r9_last;
    @(posedge clk) disable iff (!resetn)
    (reg_wr_en && (reg_addr == UDC_OFF_GAIN_PWR)) |=> (last_log_stage_off == $past(reg_wdata[6])) && !reg_rdata[3];
  endproperty
  a_r9_last: assert property (p_r9_last) else $error("last stage off bit not written"); // see R9

  property p_rd_no_strobe;
    @(posedge clk) disable iff (!resetn)
    !reg_rd_en |=> !reg_rd_valid;
  endproperty
  a_rd_no_strobe: assert property (p_rd_no_strobe) else $error("read answer without strobe"); // see R5

  property p_r5_unmapped;
    @(posedge clk) disable iff (!resetn)
    (reg_rd_en && (reg_addr != UDC_OFF_GAIN_PWR) && (reg_addr != UDC_OFF_PIN_TIME)) |=> (reg_rdata == 8'h00);
  endproperty
  a_r5_unmapped: assert property (p_r5_unmapped) else $error("unmapped read not zero"); // see R5

  property p_r2_idle;
    @(posedge clk) disable iff (!resetn)
    (dt_code == UDC_DT_CHECK_OFF) |-> (watch_en == 2'b00);
  endproperty
  a_r2_idle: assert property (p_r2_idle) else $error("pin watched with check disabled"); // see R2

  property p_r3_scheme3;
    @(posedge clk) disable iff (!resetn)
    (scheme == UDC_SCHEME_3) |-> (watch_en == 2'b00);
  endproperty
  a_r3_scheme3: assert property (p_r3_scheme3) else $error("pin watched in scheme 3"); // see R3

  property p_r3_no_pin_a;
    @(posedge clk) disable iff (!resetn)
    (scheme != UDC_SCHEME_2) |-> !watch_en[0];
  endproperty
  a_r3_no_pin_a: assert property (p_r3_no_pin_a) else $error("pin a watched outside scheme 2"); // see R3

  property p_r1_limit_long;
    @(posedge clk) disable iff (!resetn)
    (dt_code == 3'h0) |-> (limit_cyc == 12'd1280);
  endproperty
  a_r1_limit_long: assert property (p_r1_limit_long) else $error("64 us limit wrong"); // see R1

  property p_r1_limit_short;
    @(posedge clk) disable iff (!resetn)
    (dt_code == 3'h6) |-> (limit_cyc == 12'd80);
  endproperty
  a_r1_limit_short: assert property (p_r1_limit_short) else $error("4 us limit wrong"); // see R1

  c_fault_set: cover property (@(posedge clk) disable iff (!resetn) $rose(fault_r));
  c_scheme2_pause: cover property (@(posedge clk) disable iff (!resetn) watch_en[0] && both_high_pause);
  c_rd_pin_time: cover property (@(posedge clk) disable iff (!resetn)
    reg_rd_en && (reg_addr == UDC_OFF_PIN_TIME) ##1 reg_rd_valid);
  c_clear_set: cover property (@(posedge clk) disable iff (!resetn) fault_clear && (|watch_exp));

endmodule : udc_ctrl_regs
`default_nettype wire

// file: src/udc_pkg.sv
// Constants, types and decode functions of the ultrasonic device control registers
// Contract
// R1 - Deglitch field picks 64 to 4 us timeout
// R2 - Deglitch code 7 disables pulse fault check
// R3 - Schemes 0/1: quiet pin b sets fault
// R4 - Scheme 2: quiet pin a/b sets fault
// R5 - Bits 1:0 select pin control scheme
// R6 - Gain codes map to 15,10,20,12.5 V/V
// R7 - Bit 2 selects 3.3 V or 5.0 V
// R8 - Bit 7 powers down first log stage
// R9 - Bit 6 powers down last log stage
// R10 - Host writes zero to reserved bits
package udc_pkg;

  localparam logic [7:0] UDC_OFF_GAIN_PWR = 8'h13;
  localparam logic [7:0] UDC_OFF_PIN_TIME = 8'h14;
  localparam logic [7:0] UDC_RST_GAIN_PWR = 8'h00;
  localparam logic [7:0] UDC_RST_PIN_TIME = 8'h00;
  // Bit 3 of the gain register is read-only and reads as zero
  localparam logic [7:0] UDC_MASK_GAIN_PWR = 8'hF7;
  localparam logic [7:0] UDC_MASK_PIN_TIME = 8'hFF;

  localparam int UDC_BIT_FIRST_OFF = 7;
  localparam int UDC_BIT_LAST_OFF = 6;
  localparam int UDC_BIT_VOUT_SCALE = 2;
  localparam int UDC_LSB_GAIN = 0;
  localparam int UDC_LSB_DEGLITCH = 2;
  localparam int UDC_LSB_SCHEME = 0;

  localparam logic [2:0] UDC_DT_CHECK_OFF = 3'h7;

  localparam int UDC_CLK_HZ = 20_000_000;
  localparam int UDC_DT0_US = 64;
  localparam int UDC_DT1_US = 48;
  localparam int UDC_DT2_US = 32;
  localparam int UDC_DT3_US = 24;
  localparam int UDC_DT4_US = 16;
  localparam int UDC_DT5_US = 8;
  localparam int UDC_DT6_US = 4;
  localparam int UDC_LIM_W = 12;

  // Gain in half V/V steps so that 12.5 V/V stays an integer
  localparam logic [5:0] UDC_GAIN_HALF_C0 = 6'h1E;
  localparam logic [5:0] UDC_GAIN_HALF_C1 = 6'h14;
  localparam logic [5:0] UDC_GAIN_HALF_C2 = 6'h28;
  localparam logic [5:0] UDC_GAIN_HALF_C3 = 6'h19;

  typedef enum logic [1:0] {
    UDC_SCHEME_0 = 2'b00,
    UDC_SCHEME_1 = 2'b01,
    UDC_SCHEME_2 = 2'b10,
    UDC_SCHEME_3 = 2'b11
  } udc_scheme_e;

  function automatic logic [UDC_LIM_W-1:0] udc_us_to_cyc(input int us);
    udc_us_to_cyc = UDC_LIM_W'((us * (UDC_CLK_HZ / 1_000_000)));
  endfunction : udc_us_to_cyc

  function automatic logic [UDC_LIM_W-1:0] udc_timeout_cyc(input logic [2:0] code);
    case (code)
      3'h0: udc_timeout_cyc = udc_us_to_cyc(UDC_DT0_US);
      3'h1: udc_timeout_cyc = udc_us_to_cyc(UDC_DT1_US);
      3'h2: udc_timeout_cyc = udc_us_to_cyc(UDC_DT2_US);
      3'h3: udc_timeout_cyc = udc_us_to_cyc(UDC_DT3_US);
      3'h4: udc_timeout_cyc = udc_us_to_cyc(UDC_DT4_US);
      3'h5: udc_timeout_cyc = udc_us_to_cyc(UDC_DT5_US);
      3'h6: udc_timeout_cyc = udc_us_to_cyc(UDC_DT6_US);
      default: udc_timeout_cyc = '1;
    endcase
  endfunction : udc_timeout_cyc

  function automatic logic [5:0] udc_gain_half(input logic [1:0] code);
    case (code)
      2'h0: udc_gain_half = UDC_GAIN_HALF_C0;
      2'h1: udc_gain_half = UDC_GAIN_HALF_C1;
      2'h2: udc_gain_half = UDC_GAIN_HALF_C2;
      default: udc_gain_half = UDC_GAIN_HALF_C3;
    endcase
  endfunction : udc_gain_half

endpackage : udc_pkg

// file: src/udc_toggle_watch.sv
// Counts cycles since the last toggle of one burst control pin
`timescale 1ns/100ps
`default_nettype none
module udc_toggle_watch #(
  parameter int CNT_W = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic pin,
  input wire logic pause,
  input wire logic [CNT_W-1:0] limit,
  output logic expired
);
  // Refused at elaboration: a one-bit counter cannot tell a quiet pin from a toggling one
  if (CNT_W < 2) begin : g_bad_width
    $error("udc_toggle_watch: CNT_W too small");
  end

  logic pin_prev_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic expired_r;
  logic expired_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!enable || pause || (pin ^ pin_prev_r)) begin
      cnt_nxt = '0;
    end else if (cnt_r != '1) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    // Strictly longer than the limit
    expired_nxt = enable && (cnt_nxt > limit);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_prev_r <= 1'b0;
      cnt_r <= '0;
      expired_r <= 1'b0;
    end else begin
      pin_prev_r <= pin;
      cnt_r <= cnt_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;
endmodule : udc_toggle_watch
`default_nettype wire

// file: tb/udc_mcu_model.sv
// Microcontroller side: burst enable and the two burst control pins
`timescale 1ns/100ps
`default_nettype none
module udc_mcu_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic en,
  input wire logic tog_a,
  input wire logic tog_b,
  input wire logic lvl_a,
  input wire logic lvl_b,
  output logic burst_active,
  output logic pin_a,
  output logic pin_b
);
  logic [1:0] cnt_r;
  assign burst_active = en;
  // Pins change only just after an edge, as a real pin driver would
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 2'h0;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      pin_a <= tog_a ? pin_a ^ (cnt_r == 2'h3) : lvl_a;
      pin_b <= tog_b ? pin_b ^ (cnt_r == 2'h3) : lvl_b;
    end
  end
endmodule : udc_mcu_model
`default_nettype wire

// file: tb/test_udc_ctrl_regs.sv
// Self-checking bench of the control registers and pulse fault monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h exp %h", $time, a, e); end end
module test_udc_ctrl_regs;
  import udc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0, rd = 1'b0, en = 1'b0, clr = 1'b0;
  logic ta = 1'b0, tb = 1'b0, la = 1'b0, lb = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic rvalid, bact, pa, pb, flt, vout, first, last;
  logic [1:0] gsel, scheme;
  logic [5:0] ghalf;
  logic [2:0] dgl;
  int bad_count = 0, n_compared = 0, cyc = 0;
  int us_tab[7] = '{64, 48, 32, 24, 16, 8, 4};
  logic [5:0] half_tab[4] = '{6'h1E, 6'h14, 6'h28, 6'h19};
  always #25 clk = ~clk;
  udc_mcu_model i_mcu (.clk(clk), .resetn(resetn), .en(en), .tog_a(ta), .tog_b(tb), .lvl_a(la),
    .lvl_b(lb), .burst_active(bact), .pin_a(pa), .pin_b(pb));
  udc_ctrl_regs i_dut (.clk(clk), .resetn(resetn), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rvalid), .burst_active(bact),
    .burst_control_pin_a(pa), .burst_control_pin_b(pb), .fault_clear(clr),
    .driver_pulse_fault_flag(flt), .front_amplifier_gain_select(gsel),
    .front_amplifier_gain_half_vv(ghalf), .vout_full_scale_5v(vout), .first_log_stage_off(first),
    .last_log_stage_off(last), .pin_scheme(scheme), .pulse_fault_deglitch_time(dgl));
  task automatic end_sim;
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    // Tests need about 6000 cycles
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask : rd_chk
  // Runs one burst and expects a fault exactly when the quiet count passes the limit, or none
  task automatic burst(input logic [1:0] sc, input logic [2:0] code, input logic [3:0] pins, input int lim);
    int n;
    wr_reg(UDC_OFF_PIN_TIME, {3'h0, code, sc});
    ta <= pins[3];
    tb <= pins[2];
    la <= pins[1];
    lb <= pins[0];
    repeat (3) @(posedge clk);
    en <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (flt !== 1'b1 && n < ((lim > 0) ? lim + 10 : 400));
    if (lim > 0) `CHK(n, lim + 2)
    else `CHK(flt, 1'b0)
    // A clear during a live expiry must lose to the set
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    en <= 1'b0;
    #1;
    if (lim > 0) `CHK(flt, 1'b1)
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    `CHK(flt, 1'b0)
  endtask : burst
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHK(ghalf, 6'h1E)
    rd_chk(UDC_OFF_GAIN_PWR, 8'h00);
    rd_chk(UDC_OFF_PIN_TIME, 8'h00);
    for (int g = 0; g < 4; g++) begin
      wr_reg(UDC_OFF_GAIN_PWR, {g[0], g[1], 3'h0, g[1], 2'(g)});
      `CHK(gsel, 2'(g))
      `CHK(ghalf, half_tab[g])
      `CHK(vout, g[1])
      `CHK(first, g[0])
      `CHK(last, g[1])
      rd_chk(UDC_OFF_GAIN_PWR, {g[0], g[1], 3'h0, g[1], 2'(g)});
    end
    wr_reg(UDC_OFF_GAIN_PWR, 8'hFF);
    rd_chk(UDC_OFF_GAIN_PWR, 8'hF7);
    wr_reg(8'h15, 8'hAA);
    rd_chk(8'h15, 8'h00);
    rd_chk(UDC_OFF_GAIN_PWR, 8'hF7);
    wr_reg(UDC_OFF_PIN_TIME, 8'h1A);
    `CHK(scheme, 2'h2)
    `CHK(dgl, 3'h6)
    rd_chk(UDC_OFF_PIN_TIME, 8'h1A);
    for (int s = 0; s < 4; s++) begin
      wr_reg(UDC_OFF_PIN_TIME, 8'(s) | 8'hE0);
      rd_chk(UDC_OFF_PIN_TIME, 8'(s) | 8'hE0);
    end
    for (int c = 0; c < 7; c++) burst(2'h0, 3'(c), 4'h0, us_tab[c] * 20);
    burst(2'h1, 3'h6, 4'h0, 80);
    burst(2'h0, 3'h6, 4'h6, 0);
    burst(2'h0, 3'h7, 4'h0, 0);
    burst(2'h2, 3'h6, 4'h4, 80);
    burst(2'h2, 3'h6, 4'h8, 80);
    burst(2'h2, 3'h6, 4'hC, 0);
    burst(2'h2, 3'h6, 4'h3, 0);
    burst(2'h3, 3'h6, 4'h0, 0);
    end_sim();
  end
endmodule : test_udc_ctrl_regs
`default_nettype wire
